//--- core/stoi_core.sv
// transmit overhead insertion, pointer generation and path parity/febe
`timescale 1ns/10ps
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - rdi active sends 110 in k2 bits 6-8
// - rdi from pin or register bit
// - count line parity errors into z2
// - overhead clock 5.184 or 1.728 mhz
// - enable high sends serial bit, else default
// - undefined overhead bytes default to zero
// - framing and trace defaults f6 28 01 02 03
// - first pointer 62 0a, h3 zero
// - h1 h2 b1 b2 enable acts as mask
// - concatenation pointer 1001, ones, zero unused
// - normal pointer 0..782 with flag 0110
// - pointer above 782 may be sent
// - arbitrary pointer, optional flag, flag alone
// - positive justify: invert i, stuff, increment
// - negative justify: invert d, h3 data, decrement
// - pointer places path overhead, readable
// - path parity sent in next frame b3
// - register corrupts path parity continuously
// - path errors per frame, max eight, g1
// - register forces path febe value
//////////////////////////////////////////////////////////////////////////////

// three-stage synchroniser; a change is taken once stages two and three agree
module stoi_sync #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] stable_o
);
    logic [W-1:0] s1_ff;
    logic [W-1:0] s2_ff;
    logic [W-1:0] s3_ff;
    logic [W-1:0] nxt_stable;

    assign nxt_stable = (s2_ff & ~(s2_ff ^ s3_ff)) | (stable_o & (s2_ff ^ s3_ff));

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
            stable_o <= '0;
        end else begin
            s1_ff <= async_i;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            stable_o <= nxt_stable;
        end
    end
endmodule : stoi_sync

//////////////////////////////////////////////////////////////////////////////
module stoi_core (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [stoi_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [stoi_pkg::DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [stoi_pkg::DATA_W-1:0] reg_rdata_o,
    input wire logic line_rdi_request_in_i,
    input wire logic line_b2_err_i,
    input wire logic path_b3_err_i,
    input wire logic overhead_insert_clock_i,
    input wire logic overhead_serial_in_i,
    input wire logic overhead_insert_enable_i,
    input wire logic overhead_frame_position_i,
    input wire logic [7:0] payload_i,
    output logic payload_rd_o,
    output logic [7:0] tx_data_o,
    output logic tx_valid_o,
    output logic tx_frame_o
);
    import stoi_pkg::*;

    //////////////////////////////////////////////////////////////////////////
    // pin synchronisers and overhead serial capture
    logic [4:0] pin_sync;
    logic ohclk_s;
    logic ohdat_s;
    logic ohen_s;
    logic ohfp_s;
    logic rdi_pin_s;
    logic [CTL_PERSIST_W-1:0] ctrl_ff;
    logic ohclk_prev_ff;
    logic oh_rise;
    logic [9:0] ohbit_ff;
    logic [9:0] oh_cur_bit;
    logic [9:0] oh_bits;
    logic [6:0] dsh_ff;
    logic [6:0] esh_ff;
    logic [7:0] toh_val_mem [TOH_BYTES];
    logic [7:0] toh_msk_mem [TOH_BYTES];
    logic [6:0] oh_wr_idx;
    logic oh_wr;

    stoi_sync #(.W(5)) u_sync (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .async_i({line_rdi_request_in_i, overhead_frame_position_i,
                  overhead_insert_enable_i, overhead_serial_in_i, overhead_insert_clock_i}),
        .stable_o(pin_sync)
    );
    assign {rdi_pin_s, ohfp_s, ohen_s, ohdat_s, ohclk_s} = pin_sync;

    // partner changes data on the falling edge, so the rising edge sees it settled
    assign oh_rise = ohclk_s & ~ohclk_prev_ff;
    assign oh_bits = ctrl_ff[CTL_STS1] ? OH_BITS_STS1 : OH_BITS_STS3C;
    assign oh_cur_bit = ohfp_s ? 10'h000 : ohbit_ff;
    assign oh_wr_idx = oh_cur_bit[9:3];
    assign oh_wr = oh_rise && (oh_cur_bit[2:0] == 3'h7) && (oh_cur_bit < oh_bits);

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            ohclk_prev_ff <= 1'b0;
            ohbit_ff <= 10'h000;
            dsh_ff <= 7'h00;
            esh_ff <= 7'h00;
        end else begin
            ohclk_prev_ff <= ohclk_s;
            if (oh_rise) begin
                ohbit_ff <= (oh_cur_bit >= oh_bits - 10'h001) ? 10'h000 : oh_cur_bit + 10'h001;
                dsh_ff <= {dsh_ff[5:0], ohdat_s};
                esh_ff <= {esh_ff[5:0], ohen_s};
            end
        end
    end

    // masks must clear at reset so that defaults flow until the partner starts
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            for (int i = 0; i < TOH_BYTES; i++) begin
                toh_msk_mem[i] <= 8'h00;
                toh_val_mem[i] <= 8'h00;
            end
        end else if (oh_wr) begin
            toh_val_mem[oh_wr_idx] <= {dsh_ff, ohdat_s};
            toh_msk_mem[oh_wr_idx] <= {esh_ff, ohen_s};
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // register port
    logic [9:0] ptr_new_ff;
    logic [3:0] pfebe_frc_ff;
    logic pj_pend_ff;
    logic nj_pend_ff;
    logic ndf_pend_ff;
    logic load_pend_ff;
    logic load_ndf_ff;
    logic wr_ctrl;
    logic wr_ptr;
    logic wr_febe;
    logic [DATA_W-1:0] rd_mux;
    logic frame_start;

    assign wr_ctrl = reg_wr_i && (reg_addr_i == REG_CTRL);
    assign wr_ptr = reg_wr_i && (reg_addr_i == REG_PTR);
    assign wr_febe = reg_wr_i && (reg_addr_i == REG_FEBE);

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            ctrl_ff <= '0;
            ptr_new_ff <= PTR_DEFAULT;
            pfebe_frc_ff <= 4'h0;
            load_ndf_ff <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                ctrl_ff <= reg_wdata_i[CTL_PERSIST_W-1:0];
                load_ndf_ff <= reg_wdata_i[CTL_LOAD_NDF];
            end
            if (wr_ptr) begin
                ptr_new_ff <= reg_wdata_i[9:0];
            end
            if (wr_febe) begin
                pfebe_frc_ff <= reg_wdata_i[3:0];
            end
        end
    end

    // requests wait for the next frame start; a new request beats the consume
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            pj_pend_ff <= 1'b0;
            nj_pend_ff <= 1'b0;
            ndf_pend_ff <= 1'b0;
            load_pend_ff <= 1'b0;
        end else begin
            pj_pend_ff <= (pj_pend_ff & ~frame_start) | (wr_ctrl & reg_wdata_i[CTL_PJ]);
            nj_pend_ff <= (nj_pend_ff & ~frame_start) | (wr_ctrl & reg_wdata_i[CTL_NJ]);
            ndf_pend_ff <= (ndf_pend_ff & ~frame_start) | (wr_ctrl & reg_wdata_i[CTL_NDF]);
            load_pend_ff <= (load_pend_ff & ~frame_start) | (wr_ctrl & reg_wdata_i[CTL_LOAD]);
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // frame counters
    logic sts1;
    logic [1:0] div_ff;
    logic byte_en;
    logic [8:0] col_ff;
    logic [3:0] row_ff;
    logic [8:0] row_cols;
    logic [8:0] toh_cols;
    logic [8:0] spe_cols;
    logic [8:0] n_cols;

    assign sts1 = ctrl_ff[CTL_STS1];
    assign row_cols = sts1 ? ROW_COLS_STS1 : ROW_COLS_STS3C;
    assign toh_cols = sts1 ? TOH_COLS_STS1 : TOH_COLS_STS3C;
    assign spe_cols = sts1 ? SPE_COLS_STS1 : SPE_COLS_STS3C;
    assign n_cols = toh_cols / 9'h003;
    assign byte_en = (div_ff == BYTE_DIV_LAST);
    assign frame_start = byte_en && (row_ff == ROW_A) && (col_ff == 9'h000);

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            div_ff <= 2'h0;
            col_ff <= 9'h000;
            row_ff <= 4'h0;
        end else begin
            div_ff <= byte_en ? 2'h0 : div_ff + 2'h1;
            if (byte_en) begin
                col_ff <= (col_ff == row_cols - 9'h001) ? 9'h000 : col_ff + 9'h001;
                if (col_ff == row_cols - 9'h001) begin
                    row_ff <= (row_ff == ROW_LAST) ? 4'h0 : row_ff + 4'h1;
                end
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // pointer generator
    logic [9:0] ptr_ff;
    logic pos_act_ff;
    logic neg_act_ff;
    logic ndf_act_ff;
    logic align_pend_ff;
    logic [9:0] ptr_inc;
    logic [9:0] ptr_dec;
    logic [9:0] nxt_ptr;
    logic [15:0] ptr_word;
    logic align_hit;

    assign ptr_inc = (ptr_ff >= PTR_MAX) ? 10'h000 : ptr_ff + 10'h001;
    assign ptr_dec = (ptr_ff == 10'h000) ? PTR_MAX : ptr_ff - 10'h001;
    assign nxt_ptr = load_pend_ff ? ptr_new_ff :
                     pos_act_ff ? ptr_inc :
                     neg_act_ff ? ptr_dec : ptr_ff;
    // ndf 0110 normally, 1001 on a load with CTL_LOAD_NDF set or a bare flag request
    assign ptr_word = {ndf_act_ff ? NDF_NEW : NDF_NORMAL, 2'b00,
                       ptr_ff ^ (pos_act_ff ? I_MASK : 10'h000) ^ (neg_act_ff ? D_MASK : 10'h000)};

    // one justification per frame; a load in the same frame takes priority
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            ptr_ff <= PTR_DEFAULT;
            pos_act_ff <= 1'b0;
            neg_act_ff <= 1'b0;
            ndf_act_ff <= 1'b0;
            align_pend_ff <= 1'b1;
        end else if (frame_start) begin
            ptr_ff <= nxt_ptr;
            pos_act_ff <= pj_pend_ff & ~load_pend_ff;
            neg_act_ff <= nj_pend_ff & ~pj_pend_ff & ~load_pend_ff;
            ndf_act_ff <= ndf_pend_ff | (load_pend_ff & load_ndf_ff);
            align_pend_ff <= align_pend_ff | load_pend_ff;
        end else if (align_hit) begin
            align_pend_ff <= 1'b0;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // byte position decode
    logic in_toh;
    logic [1:0] grp;
    logic [1:0] sub;
    logic [6:0] toh_idx;
    logic pstuff;
    logic carry;
    logic [11:0] poff_ff;
    logic [11:0] ptr_scaled;
    logic [8:0] spe_col_ff;
    logic [3:0] spe_row_ff;
    logic [8:0] spe_col;
    logic [3:0] spe_row;
    logic poh;

    assign in_toh = col_ff < toh_cols;
    assign grp = sts1 ? col_ff[1:0] : 2'(col_ff / 9'h003);
    assign sub = sts1 ? 2'h0 : 2'(col_ff % 9'h003);
    assign toh_idx = 7'(row_ff) * 7'(toh_cols) + 7'(col_ff);
    assign pstuff = (row_ff == ROW_H) && !in_toh && (col_ff < toh_cols + n_cols);
    assign carry = (!in_toh && !(pos_act_ff && pstuff)) ||
                   (in_toh && neg_act_ff && (row_ff == ROW_H) && (grp == 2'h2));
    assign ptr_scaled = 12'(ptr_ff) * 12'(n_cols);
    // the pointer counts offsets from the byte after the last h3
    assign align_hit = byte_en && align_pend_ff && !in_toh && (poff_ff == ptr_scaled);
    assign spe_col = align_hit ? 9'h000 : spe_col_ff;
    assign spe_row = align_hit ? 4'h0 : spe_row_ff;
    assign poh = carry && (spe_col == 9'h000);

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            // reset falls at row 0, six spe rows past the h3 that zeroes the offset
            poff_ff <= 12'(SPE_COLS_STS3C) * 12'(ROW_LAST - ROW_H + 4'h1);
            spe_col_ff <= 9'h000;
            spe_row_ff <= 4'h0;
        end else if (byte_en) begin
            if ((row_ff == ROW_H) && (col_ff == toh_cols - 9'h001)) begin
                poff_ff <= 12'h000;
            end else if (!in_toh) begin
                poff_ff <= poff_ff + 12'h001;
            end
            // spe advances only on carrying bytes, so stuffing moves it by one
            if (carry) begin
                spe_col_ff <= (spe_col == spe_cols - 9'h001) ? 9'h000 : spe_col + 9'h001;
                if (spe_col == spe_cols - 9'h001) begin
                    spe_row_ff <= (spe_row == ROW_LAST) ? 4'h0 : spe_row + 4'h1;
                end
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // far end block error counters
    logic rdi;
    logic [7:0] lfebe_cnt_ff;
    logic [7:0] lfebe_ff;
    logic [7:0] lfebe_max;
    logic [3:0] pfebe_cnt_ff;
    logic [3:0] pfebe_ff;
    logic j1;

    assign rdi = ctrl_ff[CTL_RDI] | rdi_pin_s;
    assign lfebe_max = sts1 ? LFEBE_MAX_STS1 : LFEBE_MAX_STS3C;
    assign j1 = byte_en && poh && (spe_row == 4'h0);

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            lfebe_cnt_ff <= 8'h00;
            lfebe_ff <= 8'h00;
            pfebe_cnt_ff <= 4'h0;
            pfebe_ff <= 4'h0;
        end else begin
            // an error in the latching cycle starts the new count
            if (frame_start) begin
                lfebe_ff <= lfebe_cnt_ff;
                lfebe_cnt_ff <= {7'h00, line_b2_err_i};
            end else if (line_b2_err_i && (lfebe_cnt_ff < lfebe_max)) begin
                lfebe_cnt_ff <= lfebe_cnt_ff + 8'h01;
            end
            if (j1) begin
                pfebe_ff <= pfebe_cnt_ff;
                pfebe_cnt_ff <= {3'h0, path_b3_err_i};
            end else if (path_b3_err_i && (pfebe_cnt_ff < PFEBE_MAX)) begin
                pfebe_cnt_ff <= pfebe_cnt_ff + 4'h1;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // overhead byte selection
    logic [7:0] toh_def;
    logic [7:0] toh_v;
    logic [7:0] toh_m;
    logic mask_pos;
    logic [7:0] toh_mix;
    logic [7:0] toh_out;
    logic [7:0] b3_ff;
    logic [7:0] bip_ff;
    logic [7:0] poh_byte;
    logic [7:0] out_byte;

    always_comb begin
        toh_def = BYTE_ZERO;
        case (row_ff)
            ROW_A: begin
                if (grp == 2'h0) toh_def = BYTE_A1;
                else if (grp == 2'h1) toh_def = BYTE_A2;
                else if (sub == 2'h0) toh_def = BYTE_J0;
                else if (sub == 2'h1) toh_def = BYTE_Z0_2;
                else toh_def = BYTE_Z0_3;
            end
            ROW_H: begin
                if (grp == 2'h0) toh_def = (sub == 2'h0) ? ptr_word[15:8] : BYTE_H1_CAT;
                else if (grp == 2'h1) toh_def = (sub == 2'h0) ? ptr_word[7:0] : BYTE_H2_CAT;
                else toh_def = BYTE_ZERO;
            end
            ROW_LFEBE: begin
                if ((grp == 2'h1) && (sub == 2'h0)) toh_def = lfebe_ff;
            end
            default: toh_def = BYTE_ZERO;
        endcase
    end

    assign toh_v = toh_val_mem[toh_idx];
    assign toh_m = toh_msk_mem[toh_idx];
    assign mask_pos = ((row_ff == ROW_H) && (grp != 2'h2)) ||
                      ((row_ff == ROW_B1) && (grp == 2'h0) && (sub == 2'h0)) ||
                      ((row_ff == ROW_K) && (grp == 2'h0));
    assign toh_mix = mask_pos ? (toh_def ^ (toh_v & toh_m)) :
                     ((toh_def & ~toh_m) | (toh_v & toh_m));
    // rdi overrides the low k2 bits whatever the serial port supplied
    assign toh_out = ((row_ff == ROW_K) && (grp == 2'h2) && (sub == 2'h0) && rdi) ?
                     {toh_mix[7:3], K2_RDI} : toh_mix;

    always_comb begin
        case (spe_row)
            POH_B3: poh_byte = b3_ff ^ (ctrl_ff[CTL_B3_ERR] ? 8'hff : 8'h00);
            POH_C2: poh_byte = BYTE_C2;
            POH_G1: poh_byte = {ctrl_ff[CTL_PFEBE_FRC] ? pfebe_frc_ff : pfebe_ff, 4'h0};
            default: poh_byte = BYTE_ZERO;
        endcase
    end

    assign out_byte = carry ? (poh ? poh_byte : payload_i) : (in_toh ? toh_out : BYTE_ZERO);
    assign payload_rd_o = byte_en && carry && !poh;

    // parity over each spe, taken when its successor's j1 goes out
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            b3_ff <= 8'h00;
            bip_ff <= 8'h00;
        end else if (byte_en && carry) begin
            if (j1) begin
                b3_ff <= bip_ff;
                bip_ff <= out_byte;
            end else begin
                bip_ff <= bip_ff ^ out_byte;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // outputs and read data
    assign rd_mux = (reg_addr_i == REG_CTRL) ? DATA_W'({load_pend_ff, ndf_pend_ff, nj_pend_ff,
                                                        pj_pend_ff, ctrl_ff}) :
                    (reg_addr_i == REG_PTR) ? DATA_W'(ptr_ff) :
                    (reg_addr_i == REG_FEBE) ? DATA_W'(pfebe_frc_ff) :
                    (reg_addr_i == REG_STAT) ? DATA_W'({lfebe_ff, pfebe_ff, align_pend_ff,
                                                        pos_act_ff, neg_act_ff}) :
                    '0;

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            reg_rdata_o <= '0;
            tx_data_o <= 8'h00;
            tx_valid_o <= 1'b0;
            tx_frame_o <= 1'b0;
        end else begin
            reg_rdata_o <= reg_rd_i ? rd_mux : '0;
            tx_valid_o <= byte_en;
            tx_frame_o <= frame_start;
            if (byte_en) begin
                tx_data_o <= out_byte;
            end
        end
    end

endmodule : stoi_core

//--- pkg/stoi_pkg.sv
// constants for the transmit overhead insertion block
package stoi_pkg;

    // register port
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] REG_PTR = 4'h4;
    localparam logic [ADDR_W-1:0] REG_FEBE = 4'h8;
    localparam logic [ADDR_W-1:0] REG_STAT = 4'hc;

    // control register bit positions
    localparam int CTL_RDI = 0;
    localparam int CTL_B3_ERR = 1;
    localparam int CTL_PFEBE_FRC = 2;
    localparam int CTL_STS1 = 3;
    localparam int CTL_PJ = 4;
    localparam int CTL_NJ = 5;
    localparam int CTL_NDF = 6;
    localparam int CTL_LOAD = 7;
    localparam int CTL_LOAD_NDF = 8;
    localparam int CTL_PERSIST_W = 4;

    // frame geometry
    localparam logic [8:0] ROW_COLS_STS3C = 9'h10e;
    localparam logic [8:0] ROW_COLS_STS1 = 9'h05a;
    localparam logic [8:0] TOH_COLS_STS3C = 9'h009;
    localparam logic [8:0] TOH_COLS_STS1 = 9'h003;
    localparam logic [8:0] SPE_COLS_STS3C = 9'h105;
    localparam logic [8:0] SPE_COLS_STS1 = 9'h057;
    localparam logic [3:0] ROW_LAST = 4'h8;
    localparam logic [3:0] ROW_A = 4'h0;
    localparam logic [3:0] ROW_B1 = 4'h1;
    localparam logic [3:0] ROW_H = 4'h3;
    localparam logic [3:0] ROW_K = 4'h4;
    localparam logic [3:0] ROW_LFEBE = 4'h8;
    localparam logic [3:0] POH_B3 = 4'h1;
    localparam logic [3:0] POH_C2 = 4'h2;
    localparam logic [3:0] POH_G1 = 4'h3;
    localparam int TOH_BYTES = 81;

    // default overhead bytes
    localparam logic [7:0] BYTE_A1 = 8'hf6;
    localparam logic [7:0] BYTE_A2 = 8'h28;
    localparam logic [7:0] BYTE_J0 = 8'h01;
    localparam logic [7:0] BYTE_Z0_2 = 8'h02;
    localparam logic [7:0] BYTE_Z0_3 = 8'h03;
    localparam logic [7:0] BYTE_H1_CAT = 8'h93;
    localparam logic [7:0] BYTE_H2_CAT = 8'hff;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] BYTE_C2 = 8'h13;
    localparam logic [2:0] K2_RDI = 3'h6;

    // pointer word
    localparam logic [9:0] PTR_MAX = 10'h30e;
    localparam logic [9:0] PTR_DEFAULT = 10'h20a;
    localparam logic [3:0] NDF_NORMAL = 4'h6;
    localparam logic [3:0] NDF_NEW = 4'h9;
    localparam logic [9:0] I_MASK = 10'h2aa;
    localparam logic [9:0] D_MASK = 10'h155;

    // far end block error limits
    localparam logic [3:0] PFEBE_MAX = 4'h8;
    localparam logic [7:0] LFEBE_MAX_STS3C = 8'h18;
    localparam logic [7:0] LFEBE_MAX_STS1 = 8'h08;

    // overhead serial port timing: bits per frame from clock rate
    localparam int OHCLK_STS3C_KHZ = 5184;
    localparam int OHCLK_STS1_KHZ = 1728;
    localparam int FRAME_US = 125;
    localparam logic [9:0] OH_BITS_STS3C = 10'(OHCLK_STS3C_KHZ * FRAME_US / 1000);
    localparam logic [9:0] OH_BITS_STS1 = 10'(OHCLK_STS1_KHZ * FRAME_US / 1000);

    // transmit byte rate divider
    localparam logic [1:0] BYTE_DIV_LAST = 2'h1;

endpackage : stoi_pkg

//--- tb/stoi_asserts.sv
// port assertions for the overhead insertion core
`timescale 1ns/10ps
module stoi_asserts (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic reg_rd_i,
    input wire logic [stoi_pkg::DATA_W-1:0] reg_rdata_o,
    input wire logic payload_rd_o,
    input wire logic [7:0] tx_data_o,
    input wire logic tx_valid_o,
    input wire logic tx_frame_o
);
    import stoi_pkg::*;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    chk_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == '0)
        else $error("read data not zero outside answer cycle");
    chk_byte_pace: assert property (tx_valid_o |=> !tx_valid_o ##1 tx_valid_o)
        else $error("byte pulses not every second cycle");
    chk_frame_a1: assert property (tx_frame_o |-> tx_valid_o && tx_data_o == BYTE_A1)
        else $error("frame start not first framing byte");
    chk_framing_run: assert property (tx_frame_o |-> ##2 tx_data_o == BYTE_A1 ##2
        tx_data_o == BYTE_A1 ##2 tx_data_o == BYTE_A2)
        else $error("framing byte run wrong");
    chk_trace_growth: assert property (tx_frame_o |-> ##12 tx_data_o == BYTE_J0 ##2
        tx_data_o == BYTE_Z0_2 ##2 tx_data_o == BYTE_Z0_3)
        else $error("trace or growth byte wrong");
    chk_no_payload_oh: assert property (tx_frame_o |-> (!payload_rd_o) [*8])
        else $error("payload taken in overhead columns");
    chk_frame_single: assert property (tx_frame_o |=> (!tx_frame_o) [*8])
        else $error("frame marker longer than one byte");
    chk_payload_slot: assert property (payload_rd_o |=> tx_valid_o)
        else $error("payload read outside byte slot");
endmodule : stoi_asserts

bind stoi_core stoi_asserts u_stoi_asserts (.clk_i, .nrst_i, .reg_rd_i, .reg_rdata_o,
    .payload_rd_o, .tx_data_o, .tx_valid_o, .tx_frame_o);

//--- tb/stoi_oh_partner.sv
// external overhead source: fills toh bytes 15 and 27 when enabled
`timescale 1ns/10ps
module stoi_oh_partner (
    input wire logic en_i,
    input wire logic [7:0] fill_i,
    output logic ohclk_o,
    output logic ohdata_o,
    output logic ohen_o,
    output logic ohfp_o
);
    int bit_n = 0;
    initial begin
        ohclk_o = 1'b0;
        ohdata_o = 1'b0;
        ohen_o = 1'b0;
        ohfp_o = 1'b1;
        forever begin
            #160 ohclk_o = 1'b1;
            #160 ohclk_o = 1'b0;
            // lines change on the falling edge only
            bit_n = (bit_n + 1) % 648;
            ohfp_o = (bit_n == 0);
            ohen_o = en_i && (bit_n / 8 == 15 || bit_n / 8 == 27);
            // unused bits toggle so a stale value never looks valid
            ohdata_o = ohen_o ? fill_i[7 - bit_n % 8] : ~ohdata_o;
        end
    end
endmodule : stoi_oh_partner

//--- tb/sonet_tx_overhead_insert_tb.sv
// self-checking bench for the overhead insertion core
`timescale 1ns/10ps
module sonet_tx_overhead_insert_tb;
    import stoi_pkg::*;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [ADDR_W-1:0] reg_addr_i = '0;
    logic [DATA_W-1:0] reg_wdata_i = '0;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [DATA_W-1:0] reg_rdata_o;
    logic rdi_pin = 1'b0;
    logic b2_err = 1'b0;
    logic b3_err = 1'b0;
    logic oh_en = 1'b0;
    logic ohclk, ohdata, ohen, ohfp;
    logic payload_rd_o, tx_valid_o, tx_frame_o;
    logic [7:0] tx_data_o;
    logic [7:0] fr [0:2163];
    int n_errors = 0;
    int checks_done = 0;

    stoi_oh_partner u_stoi_oh_partner (.en_i(oh_en), .fill_i(8'ha5), .ohclk_o(ohclk),
        .ohdata_o(ohdata), .ohen_o(ohen), .ohfp_o(ohfp));
    stoi_core u_stoi_core (.clk_i, .nrst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
        .reg_rdata_o, .line_rdi_request_in_i(rdi_pin), .line_b2_err_i(b2_err),
        .path_b3_err_i(b3_err), .overhead_insert_clock_i(ohclk), .overhead_serial_in_i(ohdata),
        .overhead_insert_enable_i(ohen), .overhead_frame_position_i(ohfp),
        .payload_i(8'h5a), .payload_rd_o, .tx_data_o, .tx_valid_o, .tx_frame_o);

    initial forever #20 clk_i = ~clk_i;

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // trailing idle cycle keeps back-to-back writes from double-driving the strobe
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
        @(posedge clk_i);
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        @(posedge clk_i);
        chk("rdata", reg_rdata_o, exp);
    endtask : rd
    // stops at z2 so follow-up requests land before the next frame start
    task automatic grab();
        int k = 0;
        @(posedge clk_i iff tx_frame_o === 1'b1);
        fr[0] = tx_data_o;
        while (k < 2163) begin
            @(posedge clk_i iff tx_valid_o === 1'b1);
            k++;
            fr[k] = tx_data_o;
        end
    endtask : grab
    task automatic t_defaults();
        rd(4'h1, 32'h0);
        rd(REG_PTR, 32'h20a);
        grab();
        chk("h1 h2", {fr[810], fr[813]}, 16'h620a);
        chk("concat", {fr[811], fr[814]}, 16'h93ff);
        chk("h3", fr[816], 8'h00);
        chk("c2", fr[549], 8'h13);
        chk("f1", fr[276], 8'h00);
        chk("k2", fr[1086], 8'h00);
        $display("defaults done");
    endtask : t_defaults
    task automatic t_rdi();
        wr(REG_CTRL, 32'h1);
        repeat (9) begin
            {b2_err, b3_err} <= 2'h3;
            @(posedge clk_i);
            {b2_err, b3_err} <= 2'h0;
            @(posedge clk_i);
        end
        grab();
        chk("k2 reg", fr[1086], 8'h06);
        chk("z2", fr[2163], 8'h09);
        chk("g1 count", fr[819], 8'h80);
        wr(REG_FEBE, 32'h3);
        wr(REG_CTRL, 32'h4);
        rdi_pin <= 1'b1;
        grab();
        chk("k2 pin", fr[1086], 8'h06);
        chk("z2 clear", fr[2163], 8'h00);
        chk("g1 force", fr[819], 8'h30);
        rdi_pin <= 1'b0;
        $display("rdi and febe done");
    endtask : t_rdi
    task automatic t_just();
        wr(REG_CTRL, 32'h10);
        grab();
        chk("pos just", {fr[810], fr[813]}, 16'h60a0);
        wr(REG_CTRL, 32'h20);
        grab();
        chk("neg just", {fr[810], fr[813]}, 16'h635e);
        rd(REG_PTR, 32'h20b);
        grab();
        chk("ptr back", {fr[810], fr[813]}, 16'h620a);
        $display("justification done");
    endtask : t_just
    task automatic t_load();
        wr(REG_PTR, 32'h30f);
        wr(REG_CTRL, 32'h180);
        grab();
        chk("load", {fr[810], fr[813]}, 16'h930f);
        wr(REG_CTRL, 32'h40);
        grab();
        chk("flag only", {fr[810], fr[813]}, 16'h930f);
        grab();
        chk("over max", {fr[810], fr[813]}, 16'h630f);
        rd(REG_PTR, 32'h30f);
        $display("pointer load done");
    endtask : t_load
    task automatic t_port();
        oh_en <= 1'b1;
        // two full overhead frames so both bytes are stored whatever the phase
        repeat (10400) @(posedge clk_i);
        grab();
        chk("f1 ins", fr[276], 8'ha5);
        chk("h1 mask", fr[810], 8'h63 ^ 8'ha5);
        $display("overhead port done");
    endtask : t_port
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_sim

    initial begin
        repeat (4) @(posedge clk_i);
        nrst_i <= 1'b1;
        @(posedge clk_i);
        t_defaults();
        t_rdi();
        t_just();
        t_load();
        t_port();
        end_sim();
    end
    initial begin
        repeat (80000) @(posedge clk_i);
        n_errors++;
        end_sim();
    end
endmodule : sonet_tx_overhead_insert_tb
